// File: inc/psram_pkg.sv
/*
  Shared constants and types for the synchronous burst interface of a
  multiplexed address/data pseudo-static RAM.
  Assumes one system clock at 125 MHz; host pins arrive asynchronously.
*/
package psram_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int ADDR_W = 22; // Word address width (A21..A0)
  localparam int DATA_W = 16; // Word width
  localparam int UPPER_W = 6; // Address-only pins A16..A21

  // ****************************************************************
  // Bus configuration field positions
  // ****************************************************************
  localparam int BCR_MODE_BIT = 15; // 0 = synchronous modes
  localparam int BCR_LTYPE_BIT = 14; // 0 = variable latency
  localparam int BCR_LAT_HI = 13; // Latency code high bit
  localparam int BCR_LAT_LO = 11; // Latency code low bit
  localparam int BCR_POL_BIT = 10; // 1 = stall active high
  localparam int BCR_EARLY_BIT = 8; // 1 = stall one clock ahead
  localparam int BCR_BL_HI = 2; // Burst length code high bit
  localparam int BCR_BL_LO = 0; // Burst length code low bit

  // Burst length codes
  localparam logic [2:0] BL_4 = 3'h1;
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [2:0] BL_32 = 3'h4;
  localparam logic [2:0] BL_CONT = 3'h7;

  // Register select on A19:A18 (A18 set picks the identity register)
  localparam logic [1:0] SEL_REFRESH = 2'h0;
  localparam logic [1:0] SEL_BUS = 2'h2;
  localparam int SEL_A18 = 2; // Position of A18 within A16..A21
  localparam int SEL_A19 = 3; // Position of A19 within A16..A21

  // Reset values
  localparam logic [15:0] BCR_RESET = 16'h1D07; // Sync, variable, lat 3, continuous
  localparam logic [15:0] RCR_RESET = 16'h0010;
  localparam logic [15:0] PART_ID_DEFAULT = 16'h0A5A; // Arbitrary value

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  localparam int REFRESH_NS = 4000; // Refresh request interval
  localparam int REFRESH_CYC = (REFRESH_NS * CLK_MHZ) / 1000;
  localparam int SUSPEND_NS = 40; // Host clock low this long = suspend
  localparam int SUSPEND_CYC = (SUSPEND_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] REFRESH_EXTRA = 5'h02; // Latency clocks a refresh adds

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LAT, ST_XFER, ST_END} burstState_t;

  // Host-driven pins, as seen by the device
  typedef struct packed {
    logic hostClk; // Burst clock from host
    logic chipSel_n; // Chip select
    logic latch_n; // Address latch strobe
    logic write_n; // Direction, high = read
    logic outDrive_n; // Output drive enable
    logic low_byte_select_n; // Lower byte select
    logic upper_byte_select_n; // Upper byte select
    logic cfg_select; // Configuration register access
    logic [UPPER_W-1:0] addrUpper; // A16..A21
    logic [DATA_W-1:0] muxed_addr_data_bus; // Bus input value
  } hostPins_t;

  // Device-driven pins
  typedef struct packed {
    logic [DATA_W-1:0] busOut; // Bus output value
    logic busOe; // Bus output enable, high = drive
    logic stall; // Stall pin at configured polarity
  } devPins_t;

endpackage

// File: rtl/psram_word_array.sv
/*
  Word array with byte-masked synchronous write and combinational read.
  Assumes write requests come from logic on the same clock.
*/
`timescale 1ns/10ps
module psram_word_array #(
  parameter int AW = psram_pkg::ADDR_W // Array address width
) (
  input wire logic clk_sys, // System clock
  input wire logic wrEn, // Write strobe, one cycle
  input wire logic [AW-1:0] wrAddr, // Write word address
  input wire logic [psram_pkg::DATA_W-1:0] wrData, // Write word
  input wire logic [1:0] wrByte_n, // Byte selects, low = write lane
  input wire logic [AW-1:0] rdAddr, // Read word address
  output logic [psram_pkg::DATA_W-1:0] rdData // Read word
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Byte lanes written independently; one array per lane so that each
  // array has a single writing process
  genvar b;
  generate
    for (b = 0; b < 2; b++)
    begin : gLane
      logic [7:0] laneMem [0:(1<<AW)-1]; // Lane storage
      always_ff @(posedge clk_sys)
      begin
        if (wrEn && !wrByte_n[b])
        begin
          laneMem[wrAddr] <= wrData[b*8 +: 8];
        end
      end
      // Read is combinational so the next beat is ready on the data edge
      assign rdData[b*8 +: 8] = laneMem[rdAddr];
    end
  endgenerate

endmodule // psram_word_array

// File: rtl/psram_sync_burst_interface.sv
/*
  Device-side full synchronous burst engine of a multiplexed address/data
  pseudo-static RAM: address latch, latency count, stall pin, burst
  transfer, interrupt, suspend, configuration register access.
  Assumes host pins are asynchronous to clk_sys and the host clock is
  well below a quarter of clk_sys so every edge is seen.
*/
// Contract
// - Word-wide sync reads, writes; latch start address
// - Burst 4/8/16/32 or continuous from bits 2:0
// - Address on edge with latch low; data on edges
// - Direction high reads, low writes at start
// - Stall active at start, inactive during transfer
// - Latency from bits 13:11, counted from latch edge
// - Bit 14 picks latency type, variable default
// - Writes always fixed latency
// - Variable read latency grows with pending refresh
// - Fixed latency is the true latency
// - Interrupt inserts pending refresh, adds stall
// - New burst floats the data pins at once
// - Clock low suspends, address frozen, drive follows enable
// - Stall held in suspend; bit 8 sets early
// - Config registers written and read by select pin
// - Bit 15 clear plus latch edge enters sync
// - Stall polarity follows bit 10
`timescale 1ns/10ps
module psram_sync_burst_interface #(
  parameter int REFRESH_CYC = psram_pkg::REFRESH_CYC, // Refresh interval, cycles
  parameter logic [15:0] PART_ID = psram_pkg::PART_ID_DEFAULT // Arbitrary value
) (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire psram_pkg::hostPins_t hostPins, // Host pins, asynchronous
  output psram_pkg::devPins_t devPins, // Bus drive and stall pin
  output logic syncMode, // Full synchronous mode entered
  output logic [15:0] busCfg, // Bus configuration register
  output logic [15:0] refreshCfg // Refresh configuration register
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    psram_pkg::hostPins_t s1; // First synchroniser stage
    psram_pkg::hostPins_t s2; // Second synchroniser stage
    logic kPrev; // Host clock one cycle ago
    psram_pkg::burstState_t fsm; // Burst phase
    logic syncMode; // Full synchronous mode flag
    logic isRead; // Current burst reads
    logic isCfgRead; // Current burst returns a config register
    logic [psram_pkg::ADDR_W-1:0] addr; // Burst word address
    logic [5:0] beatsLeft; // Words remaining, 0 in continuous
    logic [4:0] latCnt; // Host clocks left to first data
    logic [15:0] bus_cfg_reg; // Bus configuration
    logic [15:0] refresh_cfg_reg; // Refresh configuration
    logic [15:0] cfgData; // Config word being read back
    logic [15:0] refCnt; // Refresh interval timer
    logic refPend; // Refresh owed to the array
    logic [7:0] kLowCnt; // Cycles host clock has been low
    logic wrEn; // Array write strobe
    logic [psram_pkg::ADDR_W-1:0] wrAddr; // Array write address
    logic [15:0] wrData; // Array write word
    logic [1:0] wrByte_n; // Array byte selects
    psram_pkg::devPins_t pins; // Registered device pins
  } core_t;

  core_t st_reg; // Registered state
  core_t st_next; // Next state
  logic [15:0] rdData; // Array word at burst address

  // ****************************************************************
  // Array
  // ****************************************************************
  psram_word_array #(
    .AW(psram_pkg::ADDR_W)
  ) uArray (
    .clk_sys(clk_sys),
    .wrEn(st_reg.wrEn),
    .wrAddr(st_reg.wrAddr),
    .wrData(st_reg.wrData),
    .wrByte_n(st_reg.wrByte_n),
    .rdAddr(st_reg.addr),
    .rdData(rdData)
  );

  // Burst length code to word count; continuous gives zero
  function automatic logic [5:0] burstWords(input logic [2:0] code);
    case (code)
      psram_pkg::BL_4: burstWords = 6'h04;
      psram_pkg::BL_8: burstWords = 6'h08;
      psram_pkg::BL_16: burstWords = 6'h10;
      psram_pkg::BL_32: burstWords = 6'h20;
      default: burstWords = 6'h00;
    endcase
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic kRise; // Host clock rising edge seen
    logic sel; // Chip selected
    logic startEdge; // Edge with latch strobe low
    logic varRead; // Read running at variable latency
    logic doBeat; // A word moves on this edge
    logic suspended; // Host clock held low
    logic stallAct; // Logical stall level
    logic [4:0] lat; // Latency for a new burst
    logic [1:0] regSel; // A19:A18 register select
    kRise = 1'b0;
    sel = 1'b0;
    startEdge = 1'b0;
    varRead = 1'b0;
    doBeat = 1'b0;
    suspended = 1'b0;
    stallAct = 1'b0;
    lat = 5'h00;
    regSel = 2'h0;
    st_next = st_reg;
    // Host pins pass two stages before any use
    st_next.s1 = hostPins;
    st_next.s2 = st_reg.s1;
    st_next.kPrev = st_reg.s2.hostClk;
    st_next.wrEn = 1'b0;
    kRise = st_reg.s2.hostClk & ~st_reg.kPrev;
    sel = ~st_reg.s2.chipSel_n;
    startEdge = kRise & sel & ~st_reg.s2.latch_n;
    regSel = {st_reg.s2.addrUpper[psram_pkg::SEL_A19], st_reg.s2.addrUpper[psram_pkg::SEL_A18]};

    // Refresh hides in deselected idle time
    if (!sel && st_reg.fsm == psram_pkg::ST_IDLE)
    begin
      st_next.refPend = 1'b0;
    end

    // clock held low counts toward suspend
    if (st_reg.s2.hostClk)
    begin
      st_next.kLowCnt = 8'h00;
    end
    else if (st_reg.kLowCnt < 8'(psram_pkg::SUSPEND_CYC))
    begin
      st_next.kLowCnt = st_reg.kLowCnt + 8'h01;
    end
    suspended = (st_reg.kLowCnt >= 8'(psram_pkg::SUSPEND_CYC)) && !st_reg.s2.hostClk;

    // latch edge with mode bit clear enters sync mode
    if (st_reg.bus_cfg_reg[psram_pkg::BCR_MODE_BIT])
    begin
      st_next.syncMode = 1'b0;
    end
    else if (startEdge)
    begin
      st_next.syncMode = 1'b1;
    end

    if (!sel)
    begin
      // Deselect ends any burst in any phase
      st_next.fsm = psram_pkg::ST_IDLE;
    end
    else if (startEdge && !st_reg.bus_cfg_reg[psram_pkg::BCR_MODE_BIT])
    begin
      // a new burst, even an interrupting one, floats the bus
      st_next.fsm = psram_pkg::ST_LAT;
      st_next.addr = {st_reg.s2.addrUpper, st_reg.s2.muxed_addr_data_bus};
      st_next.isRead = st_reg.s2.write_n;
      st_next.isCfgRead = st_reg.s2.cfg_select & st_reg.s2.write_n;
      st_next.beatsLeft = burstWords(st_reg.bus_cfg_reg[psram_pkg::BCR_BL_HI:psram_pkg::BCR_BL_LO]);
      // programmed latency, at least one clock
      lat = {2'h0, st_reg.bus_cfg_reg[psram_pkg::BCR_LAT_HI:psram_pkg::BCR_LAT_LO]};
      if (lat == 5'h00)
      begin
        lat = 5'h01;
      end
      varRead = st_reg.s2.write_n & ~st_reg.bus_cfg_reg[psram_pkg::BCR_LTYPE_BIT];
      // pending refresh lengthens a variable read
      if (varRead && st_reg.refPend)
      begin
        lat = lat + psram_pkg::REFRESH_EXTRA;
      end
      // fixed latency already budgets one refresh
      if (st_reg.s2.write_n)
      begin
        st_next.refPend = 1'b0;
      end
      st_next.latCnt = lat;
      if (st_reg.s2.cfg_select)
      begin
        // config write takes its value from the address word
        if (!st_reg.s2.write_n)
        begin
          st_next.fsm = psram_pkg::ST_IDLE;
          if (regSel == psram_pkg::SEL_BUS)
          begin
            st_next.bus_cfg_reg = st_reg.s2.muxed_addr_data_bus;
          end
          else if (regSel == psram_pkg::SEL_REFRESH)
          begin
            st_next.refresh_cfg_reg = st_reg.s2.muxed_addr_data_bus;
          end
        end
        // Config read returns one register, identity when A18 set
        else if (regSel[0])
        begin
          st_next.cfgData = PART_ID;
        end
        else if (regSel == psram_pkg::SEL_BUS)
        begin
          st_next.cfgData = st_reg.bus_cfg_reg;
        end
        else
        begin
          st_next.cfgData = st_reg.refresh_cfg_reg;
        end
      end
    end
    else if (kRise)
    begin
      unique case (st_reg.fsm)
        psram_pkg::ST_IDLE:
        begin
          st_next.fsm = psram_pkg::ST_IDLE;
        end
        psram_pkg::ST_LAT:
        begin
          st_next.latCnt = st_reg.latCnt - 5'h01;
          if (st_reg.latCnt <= 5'h01)
          begin
            doBeat = 1'b1;
            st_next.fsm = psram_pkg::ST_XFER;
          end
        end
        psram_pkg::ST_XFER:
        begin
          doBeat = 1'b1;
        end
        psram_pkg::ST_END:
        begin
          st_next.fsm = psram_pkg::ST_END;
        end
      endcase
    end

    // Refresh timer comes last so its set wins over either clear
    if (st_reg.refCnt >= 16'(REFRESH_CYC - 1))
    begin
      st_next.refCnt = 16'h0000;
      st_next.refPend = 1'b1;
    end
    else
    begin
      st_next.refCnt = st_reg.refCnt + 16'h0001;
    end

    // one word per edge, address steps, length ends it
    if (doBeat)
    begin
      if (st_reg.isRead)
      begin
        st_next.pins.busOut = st_reg.isCfgRead ? st_reg.cfgData : rdData;
      end
      else
      begin
        st_next.wrEn = 1'b1;
        st_next.wrAddr = st_reg.addr;
        st_next.wrData = st_reg.s2.muxed_addr_data_bus;
        st_next.wrByte_n = {st_reg.s2.upper_byte_select_n, st_reg.s2.low_byte_select_n};
      end
      st_next.addr = st_reg.addr + psram_pkg::ADDR_W'(1);
      if (st_reg.isCfgRead || st_reg.beatsLeft == 6'h01)
      begin
        st_next.fsm = psram_pkg::ST_END;
      end
      if (st_reg.beatsLeft != 6'h00)
      begin
        st_next.beatsLeft = st_reg.beatsLeft - 6'h01;
      end
    end

    // stall during latency; early option and suspend
    stallAct = (st_next.fsm == psram_pkg::ST_LAT) &&
      !(st_reg.bus_cfg_reg[psram_pkg::BCR_EARLY_BIT] && st_next.latCnt == 5'h01);
    if (st_next.fsm == psram_pkg::ST_XFER && suspended)
    begin
      stallAct = 1'b1;
    end
    st_next.pins.stall = st_reg.bus_cfg_reg[psram_pkg::BCR_POL_BIT] ? stallAct : ~stallAct;
    // drive only while output drive is low during read data
    st_next.pins.busOe = sel & st_next.isRead & ~st_reg.s2.outDrive_n &
      (st_next.fsm == psram_pkg::ST_XFER || st_next.fsm == psram_pkg::ST_END);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
      st_reg.fsm <= psram_pkg::ST_IDLE;
      st_reg.s1.chipSel_n <= 1'b1;
      st_reg.s2.chipSel_n <= 1'b1;
      st_reg.s1.latch_n <= 1'b1;
      st_reg.s2.latch_n <= 1'b1;
      st_reg.bus_cfg_reg <= psram_pkg::BCR_RESET;
      st_reg.refresh_cfg_reg <= psram_pkg::RCR_RESET;
      st_reg.wrByte_n <= 2'h3;
      st_reg.pins.stall <= ~psram_pkg::BCR_RESET[psram_pkg::BCR_POL_BIT];
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign devPins = st_reg.pins;
  assign syncMode = st_reg.syncMode;
  assign busCfg = st_reg.bus_cfg_reg;
  assign refreshCfg = st_reg.refresh_cfg_reg;

endmodule // psram_sync_burst_interface

// File: tb/psram_sync_burst_interface_asserts.sv
/*
  Port checker for the synchronous burst engine.
  Assumes it is bound onto the design, and a host clock of 8 clk_sys or more.
*/
`timescale 1ns/10ps
module psram_sync_burst_interface_asserts #(
  parameter int REFRESH_CYC = 500 // Refresh interval, cycles
) (
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Reset, active low
  input wire psram_pkg::hostPins_t hostPins, // Host pins
  input wire psram_pkg::devPins_t devPins, // Device pins
  input wire logic syncMode, // Sync mode flag
  input wire logic [15:0] busCfg, // Bus config
  input wire logic [15:0] refreshCfg // Refresh config
);
  // ********
  // Properties; pins reach the engine about 3 clk_sys late
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  bus_cfg_hold_a: assert property (
    (!hostPins.cfg_select)[*6] |=> $stable(busCfg))
    else $error("bus config changed without select");
  ref_cfg_hold_a: assert property (
    (!hostPins.cfg_select)[*6] |=> $stable(refreshCfg))
    else $error("refresh config changed without select");
  idle_stall_level_a: assert property (
    hostPins.chipSel_n[*6] |-> devPins.stall == !busCfg[psram_pkg::BCR_POL_BIT])
    else $error("idle stall level wrong");
  drive_follows_enable_a: assert property (
    hostPins.outDrive_n[*6] |-> !devPins.busOe)
    else $error("bus driven with drive disabled");
  write_no_drive_a: assert property (
    (!hostPins.write_n)[*8] |-> !devPins.busOe)
    else $error("bus driven during write");
  sync_entry_a: assert property (
    (!syncMode && hostPins.latch_n)[*8] |=> !syncMode)
    else $error("sync mode without latch edge");
  start_stall_a: assert property (
    $rose(hostPins.hostClk) && !hostPins.chipSel_n && !hostPins.latch_n
    && !hostPins.cfg_select && !busCfg[15] |-> ##[3:6] devPins.stall == busCfg[10])
    else $error("stall not raised at burst start");
  suspend_stall_a: assert property (
    (!hostPins.chipSel_n && !hostPins.hostClk)[*8] ##1
    (!hostPins.chipSel_n && !hostPins.hostClk)[*4] |-> devPins.stall == busCfg[10])
    else $error("stall not held in suspend");
endmodule // psram_sync_burst_interface_asserts

bind psram_sync_burst_interface psram_sync_burst_interface_asserts #(
  .REFRESH_CYC(REFRESH_CYC)) chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .hostPins(hostPins), .devPins(devPins), .syncMode(syncMode), .busCfg(busCfg),
  .refreshCfg(refreshCfg));

// File: tb/psram_host_model.sv
/*
  Host controller model: drives pins, records read words and stall timing.
  Assumes clk_sys at 125 MHz; one host clock is 4 low plus 4 high clk_sys.
*/
`timescale 1ns/10ps
module psram_host_model (
  input wire logic clk_sys, // System clock
  input wire psram_pkg::devPins_t devPins, // Device pins
  output psram_pkg::hostPins_t hostPins // Host pins
);
  // ********
  // Host state and burst task
  // ********
  psram_pkg::devPins_t smp; // Pins seen just before a rising edge
  logic [15:0] wq [$]; // Words to write
  logic [15:0] rq [$]; // Words read back
  int lat; // Latency seen on stall
  logic oeStart; // Drive enable after the start edge
  logic susStall; // Stall seen in suspend

  // Idle: deselected, byte lanes enabled
  initial
  begin
    hostPins = '0;
    hostPins.chipSel_n = 1'b1;
    hostPins.latch_n = 1'b1;
    hostPins.write_n = 1'b1;
    hostPins.outDrive_n = 1'b1;
  end

  // Low phase kept under the suspend limit, pins stable around the rise
  task automatic hedge();
    repeat (4) @(negedge clk_sys);
    smp = devPins;
    hostPins.hostClk = 1'b1;
    repeat (4) @(negedge clk_sys);
    hostPins.hostClk = 1'b0;
  endtask

  task automatic burst(input bit rd, cfg, input logic [21:0] a,
    input int n, lt, early, keep, susp, pol);
    int j;
    bit held;
    j = 0;
    held = 0;
    lat = -1;
    rq.delete();
    hostPins.chipSel_n = 1'b0;
    hostPins.latch_n = 1'b0;
    hostPins.write_n = rd;
    hostPins.cfg_select = cfg;
    hostPins.outDrive_n = !rd;
    {hostPins.addrUpper, hostPins.muxed_addr_data_bus} = a;
    hedge();
    hostPins.latch_n = 1'b1;
    hostPins.cfg_select = 1'b0;
    while ((rd ? rq.size() < n : j < lt + n - 1) && j < 300)
    begin
      // write words from the data edge; bus toggles when unused
      if (!rd && j + 1 >= lt) hostPins.muxed_addr_data_bus = wq[j + 1 - lt];
      else hostPins.muxed_addr_data_bus = ~hostPins.muxed_addr_data_bus;
      hedge();
      j++;
      if (j == 1) oeStart = smp.busOe;
      // stall watched for the first word
      if (lat < 0 && smp.stall !== pol) lat = j - 1 + early;
      if (rd && lat >= 0 && j > lat) rq.push_back(smp.busOut);
      // suspend only once a word is out
      if (susp && !held && rq.size() == 1)
      begin
        held = 1;
        repeat (16) @(negedge clk_sys);
        susStall = devPins.stall;
      end
    end
    // deselect right after the last word
    if (!keep)
    begin
      hostPins.chipSel_n = 1'b1;
      hedge();
    end
  endtask
endmodule // psram_host_model

// File: tb/testbench.sv
/*
  Self-checking bench: host model, reference memory, five configurations.
  Assumes the checker is bound by its own file; refresh interval shortened.
*/
`timescale 1ns/10ps
module testbench;
  // ********
  // Signals, reference model, checks
  // ********
  logic clk_sys; // System clock
  logic arst_n; // Reset, active low
  psram_pkg::hostPins_t hostPins; // Host pins
  psram_pkg::devPins_t devPins; // Device pins
  logic syncMode; // Sync mode flag
  logic [15:0] busCfg; // Bus config
  logic [15:0] refreshCfg; // Refresh config
  int error_cnt = 0; // Mismatches
  int samples_checked = 0; // Comparisons
  int cyc = 0; // Cycle count for the hang limit
  int seed = 2702; // Random seed
  logic [15:0] mem [logic [21:0]]; // Reference memory
  localparam logic [15:0] PID = 16'h3C3C; // Arbitrary identity value
  // Fixed/variable, latency 2..5, both polarities, early stall, every length
  logic [15:0] cfgs [5] = '{16'h5C01, 16'h6002, 16'h1503, 16'h6C04, 16'h1807};
  int lens [5] = '{4, 8, 16, 32, 40}; // Words per burst; last is continuous

  psram_sync_burst_interface #(.REFRESH_CYC(20), .PART_ID(PID)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .hostPins(hostPins), .devPins(devPins),
    .syncMode(syncMode), .busCfg(busCfg), .refreshCfg(refreshCfg));
  psram_host_model host (.clk_sys(clk_sys), .devPins(devPins), .hostPins(hostPins));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Runs take about 2700 cycles; the limit leaves wide margin
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin : main
    int L, len, pol, early;
    logic [21:0] a;
    logic [15:0] cfg, w;
    arst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(busCfg, psram_pkg::BCR_RESET, "bus cfg reset");
    check(refreshCfg, psram_pkg::RCR_RESET, "refresh cfg reset");
    check(syncMode, 1'b0, "sync at reset");
    for (int c = 0; c < 5; c++)
    begin
      cfg = cfgs[c];
      L = int'(cfg[13:11]);
      len = lens[c];
      pol = int'(cfg[10]);
      early = int'(cfg[8]);
      host.burst(0, 1, {6'h08, cfg}, 0, 0, 0, 0, 0, pol);
      check(busCfg, cfg, "bus cfg write");
      check(syncMode, 1'b1, "sync mode");
      a = 22'($random(seed));
      host.wq.delete();
      for (int i = 0; i <= len; i++)
      begin
        w = 16'($random(seed));
        host.wq.push_back(w);
        if (i < len || c == 4) mem[22'(a + i)] = w;
      end
      host.burst(0, 0, a, len + 1, L, early, 0, 0, pol);
      check(host.lat, L, "write latency");
      host.burst(1, 0, a, len + 1, L, early, 0, c == 4, pol);
      check(cfg[14] ? host.lat == L : host.lat == L || host.lat == L + 2, 1, "read lat");
      for (int i = 0; i <= len; i++)
        check(host.rq[i], mem[22'(a + (i < len || c == 4 ? i : len - 1))], "word");
      if (c == 4) check(host.susStall, pol, "suspend stall");
      host.burst(1, 1, {6'h08, 16'h0000}, 1, L, early, 0, 0, pol);
      check(host.rq[0], cfg, "bus cfg read");
      $display("config %0d done", c);
    end
    // Read cut short after one word, restarted without deselect
    host.burst(1, 0, a, 1, L, early, 1, 0, pol);
    host.burst(1, 0, 22'(a + 1), 2, L, early, 0, 0, pol);
    check(host.oeStart, 1'b0, "drive after restart");
    check(host.rq[0], mem[22'(a + 1)], "restart first word");
    check(host.rq[1], mem[22'(a + 2)], "restart word");
    host.burst(1, 1, {6'h04, 16'h0000}, 1, L, early, 0, 0, pol);
    check(host.rq[0], PID, "identity read");
    // Refresh configuration written and read back through the select pin
    w = 16'($random(seed));
    host.burst(0, 1, {6'h00, w}, 0, 0, 0, 0, 0, pol);
    check(refreshCfg, w, "refresh cfg write");
    check(busCfg, cfg, "bus cfg kept");
    host.burst(1, 1, {6'h00, 16'h0000}, 1, L, early, 0, 0, pol);
    check(host.rq[0], w, "refresh cfg read");
    $display("interrupt, identity and refresh cfg done");
    print_verdict();
  end
endmodule // testbench
